/* hw/pbl_regs.sv */
// Preset-two threshold level registers with split-field assembly and checksum
//
// Summary of operation
// - Level one lives in bits 7:3 of segment six register.
// - Level two joins segment six bits 2:0 with segment seven bits 7:6.
// - Level three lives in bits 5:1 of segment seven register.
// - Level four joins segment seven bit 0 with segment eight bits 7:4.
// - Level five joins segment eight bits 3:0 with segment nine bit 7.
// - Level six lives in bits 6:2 of segment nine register.
// - Level seven joins segment nine bits 1:0 with segment ten bits 7:5.
// - Level eight lives in bits 4:0 of segment ten register.
// - Levels nine to twelve are full bytes at 7Ah to 7Dh.
// - Level shift is 4-bit signed magnitude, top bit is sign.
// - Upper nibble of the offset register is reserved, read-only.
// - Level and shift fields have no defined power-up value.
// - Checksum at 7Fh recomputed on every write to these registers.
`timescale 1ns/100ps
module pbl_regs (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [6:0] i_addr,
    input wire logic [7:0] i_wr_data,
    output logic [7:0] o_rd_data,
    output logic o_rd_hit,
    output logic [4:0] o_preset_b_level_one,
    output logic [4:0] o_preset_b_level_two,
    output logic [4:0] o_preset_b_level_three,
    output logic [4:0] o_preset_b_level_four,
    output logic [4:0] o_preset_b_level_five,
    output logic [4:0] o_preset_b_level_six,
    output logic [4:0] o_preset_b_level_seven,
    output logic [4:0] o_preset_b_level_eight,
    output logic [7:0] o_preset_b_level_nine_field,
    output logic [7:0] o_preset_b_level_ten_field,
    output logic [7:0] o_preset_b_level_eleven_field,
    output logic [7:0] o_preset_b_level_twelve_field,
    output logic signed [4:0] o_preset_b_level_shift,
    output logic [7:0] o_threshold_map_checksum
);

    // One CRC-8 byte step, MSB first
    function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ pbl_pkg::CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // Convert signed magnitude nibble to two's complement
    function automatic logic signed [4:0] sm_to_tc(input logic [3:0] sm);
        logic [4:0] mag;
        mag = {2'h0, sm[2:0]};
        return sm[3] ? -$signed(mag) : $signed(mag);
    endfunction

    // Address compare shared by the single-address decodes below
    function automatic logic addr_is(input logic [6:0] addr, input logic [6:0] target);
        return addr == target;
    endfunction

    // Register storage, indexed from segment six upward
    logic [7:0] regs [pbl_pkg::NUM_REGS];
    logic [7:0] next_regs [pbl_pkg::NUM_REGS];
    logic [pbl_pkg::NUM_REGS-1:0] wr_sel;
    logic [7:0] next_checksum;
    logic [7:0] checksum;
    logic [7:0] rd_window;
    logic [7:0] rd_mux;
    logic [7:0] next_rd_data;
    logic next_rd_hit;
    logic rd_valid;
    logic [3:0] reg_index;
    logic wr_hit;
    logic wr_take;
    logic wr_offset;
    logic rd_checksum;
    logic [7:0] wr_image;

    // Named views of the stored segments
    // Keeps the level wiring readable against the register map
    logic [7:0] seg6;
    logic [7:0] seg7;
    logic [7:0] seg8;
    logic [7:0] seg9;
    logic [7:0] seg10;
    logic [7:0] level_nine_reg;
    logic [7:0] level_ten_reg;
    logic [7:0] level_eleven_reg;
    logic [7:0] level_twelve_reg;
    logic [7:0] offset_reg;

    // Assembled values ahead of the output flops
    logic [4:0] next_level_one;
    logic [4:0] next_level_two;
    logic [4:0] next_level_three;
    logic [4:0] next_level_four;
    logic [4:0] next_level_five;
    logic [4:0] next_level_six;
    logic [4:0] next_level_seven;
    logic [4:0] next_level_eight;
    logic [7:0] next_level_nine;
    logic [7:0] next_level_ten;
    logic [7:0] next_level_eleven;
    logic [7:0] next_level_twelve;
    logic signed [4:0] next_level_shift;

    // Address decode for the writable window
    // Index is only meaningful while the window is hit
    assign wr_hit = (i_addr >= pbl_pkg::SEG6_ADDR) && (i_addr <= pbl_pkg::OFFSET_ADDR);
    assign reg_index = 4'(i_addr - pbl_pkg::SEG6_ADDR);
    assign wr_take = i_wr_en && wr_hit;
    assign wr_offset = addr_is(i_addr, pbl_pkg::OFFSET_ADDR);
    assign rd_checksum = addr_is(i_addr, pbl_pkg::CHECKSUM_ADDR);

    // reserved nibble forced on the way in
    // Software can never park data in the upper nibble
    assign wr_image = wr_offset ? {pbl_pkg::RESERVED_NIBBLE, i_wr_data[3:0]} : i_wr_data;

    // One write select per register
    // Only one select can be high, as addresses are distinct
    assign wr_sel[0] = i_wr_en && addr_is(i_addr, pbl_pkg::SEG6_ADDR);
    assign wr_sel[1] = i_wr_en && addr_is(i_addr, pbl_pkg::SEG7_ADDR);
    assign wr_sel[2] = i_wr_en && addr_is(i_addr, pbl_pkg::SEG8_ADDR);
    assign wr_sel[3] = i_wr_en && addr_is(i_addr, pbl_pkg::SEG9_ADDR);
    assign wr_sel[4] = i_wr_en && addr_is(i_addr, pbl_pkg::SEG10_ADDR);
    assign wr_sel[5] = i_wr_en && addr_is(i_addr, pbl_pkg::NINE_ADDR);
    assign wr_sel[6] = i_wr_en && addr_is(i_addr, pbl_pkg::TEN_ADDR);
    assign wr_sel[7] = i_wr_en && addr_is(i_addr, pbl_pkg::ELEVEN_ADDR);
    assign wr_sel[8] = i_wr_en && addr_is(i_addr, pbl_pkg::TWELVE_ADDR);
    assign wr_sel[9] = i_wr_en && addr_is(i_addr, pbl_pkg::OFFSET_ADDR);

    // Next content of each register, held unless selected
    assign next_regs[0] = wr_sel[0] ? wr_image : regs[0];
    assign next_regs[1] = wr_sel[1] ? wr_image : regs[1];
    assign next_regs[2] = wr_sel[2] ? wr_image : regs[2];
    assign next_regs[3] = wr_sel[3] ? wr_image : regs[3];
    assign next_regs[4] = wr_sel[4] ? wr_image : regs[4];
    assign next_regs[5] = wr_sel[5] ? wr_image : regs[5];
    assign next_regs[6] = wr_sel[6] ? wr_image : regs[6];
    assign next_regs[7] = wr_sel[7] ? wr_image : regs[7];
    assign next_regs[8] = wr_sel[8] ? wr_image : regs[8];
    assign next_regs[9] = wr_sel[9] ? wr_image : regs[9];

    // no reset on field storage
    // Contents stay unknown until software writes them
    always_ff @(posedge i_sys_clk) begin
        for (int n = 0; n < pbl_pkg::NUM_REGS; n++) begin
            regs[n] <= next_regs[n];
        end
    end

    // Checksum over the image as it will stand after this write
    // Folding in the new byte now lets the flop update on the same edge
    always_comb begin
        logic [7:0] img;
        img = 8'h00;
        next_checksum = pbl_pkg::CRC_SEED;
        for (int k = 0; k < pbl_pkg::NUM_REGS; k++) begin
            img = next_regs[k];
            next_checksum = crc_byte(next_checksum, img);
        end
    end

    // refresh checksum on any write to the window
    // Holds between writes, so reads see the last image
    always_ff @(posedge i_sys_clk) begin
        if (wr_take) begin
            checksum <= next_checksum;
        end
    end

    // Read data selection, checksum byte just above the window
    assign rd_valid = wr_hit || rd_checksum;
    assign rd_window = wr_hit ? regs[reg_index] : 8'h00;
    assign rd_mux = rd_checksum ? checksum : rd_window;
    assign next_rd_data = i_rd_en ? rd_mux : 8'h00;
    assign next_rd_hit = i_rd_en && rd_valid;

    // Registered read data, zero when idle
    // Idle zero keeps a bus OR of several banks clean
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= 8'h00;
        end else begin
            o_rd_data <= next_rd_data;
        end
    end

    // Registered read hit, one cycle per read
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_hit <= 1'b0;
        end else begin
            o_rd_hit <= next_rd_hit;
        end
    end

    // Segment views in address order
    assign seg6 = regs[0];
    assign seg7 = regs[1];
    assign seg8 = regs[2];
    assign seg9 = regs[3];
    assign seg10 = regs[4];
    assign level_nine_reg = regs[5];
    assign level_ten_reg = regs[6];
    assign level_eleven_reg = regs[7];
    assign level_twelve_reg = regs[8];
    assign offset_reg = regs[9];

    // Level assembly, pure wiring of stored bits

    // level one whole in segment six
    assign next_level_one = seg6[7:3];

    // pieces may come from two separate writes
    // level two split over segments six and seven
    assign next_level_two = {seg6[2:0], seg7[7:6]};

    // level three whole in segment seven
    assign next_level_three = seg7[5:1];

    // pieces may come from two separate writes
    // level four split over segments seven and eight
    assign next_level_four = {seg7[0], seg8[7:4]};

    // pieces may come from two separate writes
    // level five split over segments eight and nine
    assign next_level_five = {seg8[3:0], seg9[7]};

    // level six whole in segment nine
    assign next_level_six = seg9[6:2];

    // pieces may come from two separate writes
    // level seven split over segments nine and ten
    assign next_level_seven = {seg9[1:0], seg10[7:5]};

    // level eight whole in segment ten
    assign next_level_eight = seg10[4:0];

    // full byte levels at the top of the window
    // Stored and shown as written, no packing
    assign next_level_nine = level_nine_reg;
    assign next_level_ten = level_ten_reg;
    assign next_level_eleven = level_eleven_reg;
    assign next_level_twelve = level_twelve_reg;

    // signed magnitude nibble to two's complement
    // Minus zero folds to zero, so minus eight is never produced
    assign next_level_shift = sm_to_tc(offset_reg[3:0]);

    // Output flops, one per field so every output is a plain register
    // No reset here either, outputs mirror storage one cycle late

    // Settles one cycle after the store
    // level one output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_one <= next_level_one;
    end

    // Either half may change it
    // level two output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_two <= next_level_two;
    end

    // Settles one cycle after the store
    // level three output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_three <= next_level_three;
    end

    // Either half may change it
    // level four output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_four <= next_level_four;
    end

    // Either half may change it
    // level five output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_five <= next_level_five;
    end

    // Settles one cycle after the store
    // level six output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_six <= next_level_six;
    end

    // Either half may change it
    // level seven output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_seven <= next_level_seven;
    end

    // Settles one cycle after the store
    // level eight output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_eight <= next_level_eight;
    end

    // Byte copy of its register
    // level nine output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_nine_field <= next_level_nine;
    end

    // Byte copy of its register
    // level ten output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_ten_field <= next_level_ten;
    end

    // Byte copy of its register
    // level eleven output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_eleven_field <= next_level_eleven;
    end

    // Byte copy of its register
    // level twelve output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_twelve_field <= next_level_twelve;
    end

    // Already converted, users add it directly
    // level shift output
    always_ff @(posedge i_sys_clk) begin
        o_preset_b_level_shift <= next_level_shift;
    end

    // Trails the checksum register by one cycle
    // checksum output
    always_ff @(posedge i_sys_clk) begin
        o_threshold_map_checksum <= checksum;
    end

endmodule

/* hw/pbl_pkg.sv */
// Constants for the preset-two threshold level register bank
package pbl_pkg;
    localparam logic [6:0] SEG6_ADDR = 7'h75;
    localparam logic [6:0] SEG7_ADDR = 7'h76;
    localparam logic [6:0] SEG8_ADDR = 7'h77;
    localparam logic [6:0] SEG9_ADDR = 7'h78;
    localparam logic [6:0] SEG10_ADDR = 7'h79;
    localparam logic [6:0] NINE_ADDR = 7'h7A;
    localparam logic [6:0] TEN_ADDR = 7'h7B;
    localparam logic [6:0] ELEVEN_ADDR = 7'h7C;
    localparam logic [6:0] TWELVE_ADDR = 7'h7D;
    localparam logic [6:0] OFFSET_ADDR = 7'h7E;
    localparam logic [6:0] CHECKSUM_ADDR = 7'h7F;
    localparam int NUM_REGS = 10;
    localparam logic [3:0] RESERVED_NIBBLE = 4'h0;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_SEED = 8'hFF;
endpackage

/* dv/pbl_ctl.sv */
// Controller model issuing register requests
`timescale 1ns/100ps
module pbl_ctl (input wire logic i_sys_clk, output logic o_we = 1'b0, o_re = 1'b0, output logic [6:0] o_a = 7'h00,
    output logic [7:0] o_d = 8'h00);
    // One request just after the edge, idle data inverted
    task automatic xfer(input logic w, r, input logic [6:0] a, input logic [7:0] d);
        @(posedge i_sys_clk) #1 {o_we, o_re, o_a, o_d} = {w, r, a, w ? d : ~o_d};
    endtask
endmodule

/* dv/pbl_chk.sv */
// Port checker for the level register bank
`timescale 1ns/100ps
module pbl_chk (input wire logic i_sys_clk, i_reset_n, i_wr_en, i_rd_en, o_rd_hit, input wire logic [6:0] i_addr,
    input wire logic [7:0] i_wr_data, o_rd_data, o_preset_b_level_nine_field, o_preset_b_level_ten_field,
    o_preset_b_level_eleven_field, o_preset_b_level_twelve_field, input wire logic [4:0]
    o_preset_b_level_one, o_preset_b_level_three, o_preset_b_level_six, o_preset_b_level_eight);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    a_lvl_one: assert property (i_wr_en && i_addr == 7'h75 |->
        ##2 o_preset_b_level_one == $past(i_wr_data[7:3], 2)) else $error("level one");
    a_lvl_three: assert property (i_wr_en && i_addr == 7'h76 |->
        ##2 o_preset_b_level_three == $past(i_wr_data[5:1], 2)) else $error("level three");
    a_lvl_six: assert property (i_wr_en && i_addr == 7'h78 |->
        ##2 o_preset_b_level_six == $past(i_wr_data[6:2], 2)) else $error("level six");
    a_lvl_eight: assert property (i_wr_en && i_addr == 7'h79 |->
        ##2 o_preset_b_level_eight == $past(i_wr_data[4:0], 2)) else $error("level eight");
    a_lvl_nine: assert property (i_wr_en && i_addr == 7'h7A |->
        ##2 o_preset_b_level_nine_field == $past(i_wr_data, 2)) else $error("level nine");
    a_lvl_ten: assert property (i_wr_en && i_addr == 7'h7B |->
        ##2 o_preset_b_level_ten_field == $past(i_wr_data, 2)) else $error("level ten");
    a_lvl_eleven: assert property (i_wr_en && i_addr == 7'h7C |->
        ##2 o_preset_b_level_eleven_field == $past(i_wr_data, 2)) else $error("level eleven");
    a_lvl_twelve: assert property (i_wr_en && i_addr == 7'h7D |->
        ##2 o_preset_b_level_twelve_field == $past(i_wr_data, 2)) else $error("level twelve");
    a_rd_hit: assert property (o_rd_hit == ($past(i_rd_en) && $past(i_addr) >= 7'h75)) else $error("hit");
    a_rd_idle: assert property (!o_rd_hit |-> o_rd_data == 8'h00) else $error("idle data");
    a_rd_rsvd: assert property (i_rd_en && i_addr == 7'h7E |=> o_rd_data[7:4] == 4'h0) else $error("nibble");
endmodule
bind pbl_regs pbl_chk u_chk (.*);

/* dv/pbl_regs_tb.sv */
// Bench for the level register bank
`timescale 1ns/100ps
module pbl_regs_tb;
    logic clk = 1'b0, rn = 1'b0, we, re, hit;
    logic [6:0] a;
    logic [7:0] d, rd, cs, c, m[10], q[$];
    logic [4:0] l2, l4, l5, l7, sh;
    int fail_count = 0, checked = 0, seed = 32'h271EF500, i, r, k;
    pbl_ctl ctl (.i_sys_clk(clk), .o_we(we), .o_re(re), .o_a(a), .o_d(d));
    pbl_regs dut (.i_sys_clk(clk), .i_reset_n(rn), .i_wr_en(we), .i_rd_en(re), .i_addr(a), .i_wr_data(d),
        .o_rd_data(rd), .o_rd_hit(hit), .o_preset_b_level_one(), .o_preset_b_level_two(l2),
        .o_preset_b_level_three(), .o_preset_b_level_four(l4), .o_preset_b_level_five(l5),
        .o_preset_b_level_six(), .o_preset_b_level_seven(l7), .o_preset_b_level_eight(),
        .o_preset_b_level_nine_field(), .o_preset_b_level_ten_field(), .o_preset_b_level_eleven_field(),
        .o_preset_b_level_twelve_field(), .o_preset_b_level_shift(sh), .o_threshold_map_checksum(cs));
    // Clock
    initial forever #10 clk = ~clk;
    // Compare and count
    task automatic chk(input logic [23:0] g, e);
        checked++;
        fail_count += int'(g !== e);
        if (g !== e) $display("[FAIL] %0t %h %h", $time, g, e);
    endtask
    // Counts and verdict
    task automatic stop_test;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Read data against the oldest note
    always @(negedge clk) if (hit === 1'b1) chk(rd, q.size() ? q.pop_front() : 8'hXX);
    // Hang guard
    initial begin
        #99000;
        fail_count++;
        stop_test;
    end
    // Random full then partial writes, back-to-back reads, field checks
    initial begin
        repeat (3) @(posedge clk);
        #1 rn = 1'b1;
        for (r = 0; r < 4; r++) begin
            for (i = 0; i < 10; i++) if (r == 0 || $random(seed) & 1) begin
                m[i] = 8'($random(seed));
                ctl.xfer(1, 0, 7'h75 + 7'(i), m[i]);
            end
            m[9][7:4] = 4'h0;
            c = 8'hFF;
            for (k = 0; k < 80; k++) c = {c[6:0], 1'b0} ^ (c[7] ^ m[k / 8][7 - k % 8] ? 8'h07 : 8'h00);
            for (i = 0; i < 12; i++) begin
                if (i < 11) q.push_back(i < 10 ? m[i] : c);
                ctl.xfer(0, 1, i < 11 ? 7'h75 + 7'(i) : 7'h10, 8'h00);
            end
            ctl.xfer(0, 0, 7'h00, 8'h00);
            @(posedge clk);
            chk({l2, l4, l5, l7}, {m[0][2:0], m[1][7:6], m[1][0], m[2][7:0], m[3][7], m[3][1:0], m[4][7:5]});
            chk({sh, cs}, {m[9][3] ? 5'h00 - m[9][2:0] : 5'h00 + m[9][2:0], c});
        end
        stop_test;
    end
endmodule
